// ===== hdl/ext_access.sv
// external access sequencer: overlay mapping, wait states, i/o space
// assumes the core holds i_req until o_done and config changes only when idle
`timescale 1ns/1ps
module ext_access (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cfg_we,
    input wire ext_access_pkg::wait_cfg_t i_cfg,
    input wire logic i_req,
    input wire ext_access_pkg::req_t i_req_info,
    input wire logic [15:0] i_ext_rdata,
    output ext_access_pkg::wait_cfg_t o_cfg,
    output ext_access_pkg::ext_bus_t o_bus,
    output logic o_internal,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic o_busy
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_LAST,
        ST_SYNC1,
        ST_SYNC2
    } state_t;

    state_t state_r;
    ext_access_pkg::wait_cfg_t cfg_r;
    logic [3:0] cnt_r;
    logic [3:0] waits;
    logic [2:0] sel_count;
    logic [15:0] rdata_s1_r;
    logic [15:0] rdata_s2_r;
    logic start;
    logic dm_window;
    logic to_internal;
    logic finish;

    // region decode used by wait selection
    function automatic logic [1:0] io_region(input logic [13:0] a);
        return a[ext_access_pkg::IO_REGION_HI:ext_access_pkg::IO_REGION_LO];
    endfunction

    assign dm_window = i_req_info.addr >= ext_access_pkg::DM_WINDOW_BASE;
    assign to_internal = (i_req_info.space == ext_access_pkg::SPACE_DM) && (!dm_window
        || cfg_r.data_overlay_select == ext_access_pkg::OVL_INTERNAL);
    assign start = i_req && state_r == ST_IDLE && !o_done;
    // reads finish two cycles late: the last strobed pin word must clear the synchroniser
    assign finish = (state_r == ST_LAST && o_bus.rd_b) || state_r == ST_SYNC2;

    always_comb begin
        unique case (i_req_info.space)
            ext_access_pkg::SPACE_PM: sel_count = cfg_r.program_memory_wait_count;
            ext_access_pkg::SPACE_DM: sel_count = cfg_r.data_memory_wait_count;
            default: sel_count =
                cfg_r.io_region_wait_counts[io_region(i_req_info.addr)];
        endcase
    end

    wait_count_calc u_calc (
        .i_count(sel_count),
        .i_mode_2n1(cfg_r.wait_mode_2n1),
        .o_waits(waits)
    );

    // config register; defaults give seven waits on every space, the slowest normal-mode timing, before software runs
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_r.program_memory_wait_count <= ext_access_pkg::WAIT_RST;
            cfg_r.data_memory_wait_count <= ext_access_pkg::WAIT_RST;
            cfg_r.io_region_wait_counts <= {4{ext_access_pkg::WAIT_RST}};
            cfg_r.wait_mode_2n1 <= ext_access_pkg::MODE_RST;
            cfg_r.data_overlay_select <= ext_access_pkg::OVL_RST;
        end else if (i_cfg_we && state_r == ST_IDLE) begin
            cfg_r <= i_cfg;
        end
    end
    assign o_cfg = cfg_r;

    // sequencer
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start && !to_internal) begin
                        cnt_r <= waits;
                        state_r <= (waits == 4'h0) ? ST_LAST : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_r <= ST_LAST;
                    end
                end
                ST_LAST: begin
                    state_r <= o_bus.rd_b ? ST_IDLE : ST_SYNC1;
                end
                ST_SYNC1: state_r <= ST_SYNC2;
                ST_SYNC2: state_r <= ST_IDLE;
            endcase
        end
    end

    // external bus; held steady from request through the last wait
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus <= '{addr: 14'h0000, wdata: 16'h0000, pm_sel_b: 1'b1, dm_sel_b: 1'b1,
                       io_sel_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, data_oe: 1'b0};
        end else if (state_r == ST_IDLE && start && !to_internal) begin
            o_bus.wdata <= i_req_info.wdata;
            o_bus.rd_b <= i_req_info.write;
            o_bus.wr_b <= !i_req_info.write;
            o_bus.data_oe <= i_req_info.write;
            o_bus.pm_sel_b <= i_req_info.space != ext_access_pkg::SPACE_PM;
            o_bus.dm_sel_b <= i_req_info.space != ext_access_pkg::SPACE_DM;
            o_bus.io_sel_b <= i_req_info.space != ext_access_pkg::SPACE_IO;
            if (i_req_info.space == ext_access_pkg::SPACE_IO) begin
                // upper lines left at zero: software must not read meaning there
                o_bus.addr <= {3'h0,
                    i_req_info.addr[ext_access_pkg::IO_ADDR_W-1:0]};
            end else if (i_req_info.space == ext_access_pkg::SPACE_DM) begin
                o_bus.addr <= {cfg_r.data_overlay_select == ext_access_pkg::OVL_REGION2,
                    i_req_info.addr[ext_access_pkg::OVL_LOW_W-1:0]};
            end else begin
                o_bus.addr <= i_req_info.addr;
            end
        end else if (state_r == ST_LAST) begin
            o_bus.pm_sel_b <= 1'b1;
            o_bus.dm_sel_b <= 1'b1;
            o_bus.io_sel_b <= 1'b1;
            o_bus.rd_b <= 1'b1;
            o_bus.wr_b <= 1'b1;
            o_bus.data_oe <= 1'b0;
        end
    end

    // read data is a pin: two stages before use; sampled at end of strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_s1_r <= 16'h0000;
            rdata_s2_r <= 16'h0000;
        end else begin
            rdata_s1_r <= i_ext_rdata;
            rdata_s2_r <= rdata_s1_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_done <= 1'b0;
            o_internal <= 1'b0;
            o_rdata <= 16'h0000;
            o_busy <= 1'b0;
        end else begin
            o_done <= (start && to_internal) || finish;
            o_internal <= start && to_internal;
            o_busy <= (start && !to_internal) || (state_r != ST_IDLE && !finish);
            // second stage now holds the pin word of the last strobed cycle
            if (state_r == ST_SYNC2) begin
                o_rdata <= rdata_s2_r;
            end
        end
    end

    sequence s_ext_start;
        state_r == ST_IDLE && start && !to_internal;
    endsequence

    property p_internal_one_cycle;
        @(posedge i_clk) disable iff (!i_rst_b)
        (start && to_internal) |=> o_done && o_internal && o_bus.dm_sel_b;
    endproperty
    a_internal_one_cycle: assert property (p_internal_one_cycle)
        else $error("internal late");

    property p_zero_wait;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_ext_start and waits == 4'h0)
            |=> (o_bus.rd_b ##1 o_done) or (!o_bus.rd_b ##3 o_done);
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("zero wait wrong");

    property p_normal_seven;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_ext_start and !cfg_r.wait_mode_2n1 and sel_count == 3'h7)
            |=> !o_done [*7] ##1 state_r == ST_LAST;
    endproperty
    a_normal_seven: assert property (p_normal_seven) else $error("normal count wrong");

    property p_mode_waits;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_ext_start and cfg_r.wait_mode_2n1) |-> waits == {sel_count, 1'b1};
    endproperty
    a_mode_waits: assert property (p_mode_waits) else $error("2n+1 wrong");

    property p_hold_strobes;
        @(posedge i_clk) disable iff (!i_rst_b)
        (state_r == ST_WAIT)
            |=> $stable(o_bus.addr) && $stable(o_bus.rd_b) && !o_bus.rd_b != !o_bus.wr_b;
    endproperty
    a_hold_strobes: assert property (p_hold_strobes) else $error("bus moved in wait");

    property p_read_capture;
        @(posedge i_clk) disable iff (!i_rst_b)
        (state_r == ST_LAST && !o_bus.rd_b) |=> !o_done ##1 !o_done ##1 o_done;
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read done early");

    property p_io_addr;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_ext_start and i_req_info.space == ext_access_pkg::SPACE_IO)
            |=> !o_bus.io_sel_b && o_bus.addr[10:0] == $past(i_req_info.addr[10:0]);
    endproperty
    a_io_addr: assert property (p_io_addr) else $error("io address wrong");

    property p_ovl2;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_ext_start and i_req_info.space == ext_access_pkg::SPACE_DM
            and cfg_r.data_overlay_select == ext_access_pkg::OVL_REGION2) |=> o_bus.addr[13];
    endproperty
    a_ovl2: assert property (p_ovl2) else $error("overlay 2 line 13");

    property p_ovl1;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_ext_start and i_req_info.space == ext_access_pkg::SPACE_DM
            and cfg_r.data_overlay_select == ext_access_pkg::OVL_REGION1) |=> !o_bus.addr[13];
    endproperty
    a_ovl1: assert property (p_ovl1) else $error("overlay 1 line 13");

    property p_region_count;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_ext_start and i_req_info.space == ext_access_pkg::SPACE_IO)
            |-> sel_count == cfg_r.io_region_wait_counts[i_req_info.addr[10:9]];
    endproperty
    a_region_count: assert property (p_region_count) else $error("io region count");
endmodule

// ===== hdl/ext_access_pkg.sv
// constants and carrier types for the external access block
// assumes a single instruction clock drives every user of this package
package ext_access_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 3;
    localparam int CNT_W = 4;
    localparam int IO_ADDR_W = 11;
    localparam int IO_REGION_HI = 10;
    localparam int IO_REGION_LO = 9;
    localparam int OVL_LOW_W = 13;
    localparam int OVL_BIT = 13;
    localparam logic [13:0] DM_WINDOW_BASE = 14'h2000;
    localparam logic [1:0] OVL_INTERNAL = 2'h0;
    localparam logic [1:0] OVL_REGION1 = 2'h1;
    localparam logic [1:0] OVL_REGION2 = 2'h2;
    localparam logic [2:0] WAIT_RST = 3'h7;
    localparam logic MODE_RST = 1'h0;
    localparam logic [1:0] OVL_RST = 2'h0;

    typedef enum logic [1:0] {
        SPACE_PM,
        SPACE_DM,
        SPACE_IO
    } space_t;

    typedef struct packed {
        logic [2:0] program_memory_wait_count;
        logic [2:0] data_memory_wait_count;
        logic [3:0][2:0] io_region_wait_counts;
        logic wait_mode_2n1;
        logic [1:0] data_overlay_select;
    } wait_cfg_t;

    typedef struct packed {
        space_t space;
        logic write;
        logic [13:0] addr;
        logic [15:0] wdata;
    } req_t;

    typedef struct packed {
        logic [13:0] addr;
        logic [15:0] wdata;
        logic pm_sel_b;
        logic dm_sel_b;
        logic io_sel_b;
        logic rd_b;
        logic wr_b;
        logic data_oe;
    } ext_bus_t;
endpackage

// ===== hdl/wait_count_calc.sv
// converts a three-bit wait count into inserted wait states
// assumes the mode bit is stable while an access is running
`timescale 1ns/1ps
module wait_count_calc (
    input wire logic [2:0] i_count,
    input wire logic i_mode_2n1,
    output logic [3:0] o_waits
);
    always_comb begin
        if (i_mode_2n1) begin
            o_waits = {i_count, 1'b1};
        end else begin
            o_waits = {1'b0, i_count};
        end
    end
endmodule

// ===== tb/ext_periph_model.sv
// peripheral model on the external bus: stores writes, answers reads
// assumes registered active-low selects and strobes from the access block
`timescale 1ns/1ps
module ext_periph_model (
    input wire logic i_clk,
    input wire ext_access_pkg::ext_bus_t i_bus,
    output logic [15:0] o_rdata,
    output logic [2:0] o_sel,
    output logic [13:0] o_addr,
    output logic o_we,
    output logic o_unstable
);
    logic [15:0] mem [64];
    logic [15:0] last = 16'h0;
    logic strobe_r = 1'b0;
    wire logic [2:0] sel = {i_bus.pm_sel_b, i_bus.dm_sel_b, i_bus.io_sel_b};
    wire logic [1:0] sp = !i_bus.pm_sel_b ? 2'h0 : !i_bus.dm_sel_b ? 2'h1 : 2'h2;
    wire logic [5:0] idx = {sp, i_bus.addr[3:0]};
    wire logic strobe = !(i_bus.rd_b && i_bus.wr_b);
    initial begin
        o_unstable = 1'b0;
        for (int i = 0; i < 64; i++) mem[i] = 16'hC000 | 16'(i);
    end
    // no pull-up: released lines show the inverse of the last word
    assign o_rdata = (sel != 3'h7 && i_bus.wr_b) ? mem[idx] : ~last;
    always @(posedge i_clk) begin
        last <= o_rdata;
        strobe_r <= strobe;
        if (strobe) begin
            o_sel <= sel;
            o_addr <= i_bus.addr;
            o_we <= !i_bus.wr_b;
            if (strobe_r && i_bus.addr !== o_addr) o_unstable <= 1'b1;
        end
        if (!i_bus.wr_b && i_bus.data_oe) mem[idx] <= i_bus.wdata;
    end
endmodule

// ===== tb/tb_wait_state_overlay_io_space.sv
// self-checking bench for the external access sequencer
// assumes the peripheral model sits on o_bus and feeds i_ext_rdata
`timescale 1ns/1ps
module tb_wait_state_overlay_io_space;
    localparam ext_access_pkg::space_t PM = ext_access_pkg::SPACE_PM;
    localparam ext_access_pkg::space_t DM = ext_access_pkg::SPACE_DM;
    localparam ext_access_pkg::space_t IO = ext_access_pkg::SPACE_IO;
    typedef struct packed {
        ext_access_pkg::space_t sp;
        logic wr;
        logic [13:0] addr;
        logic [15:0] wdata;
        logic [1:0] ovl;
        logic [13:0] eaddr;
        logic intl;
        logic [15:0] rdata;
    } row_t;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_cfg_we = 1'b0;
    ext_access_pkg::wait_cfg_t i_cfg = '0;
    logic i_req = 1'b0;
    ext_access_pkg::req_t i_req_info = '0;
    logic [15:0] i_ext_rdata;
    ext_access_pkg::wait_cfg_t o_cfg;
    ext_access_pkg::ext_bus_t o_bus;
    logic o_internal, o_done, o_busy, m_we, m_bad, poke, busy1;
    logic [15:0] o_rdata;
    logic [2:0] m_sel;
    logic [13:0] m_addr;
    int bad_count = 0;
    int total_checks = 0;
    int lat;
    int want;
    row_t rows [11];
    initial forever #4 i_clk = ~i_clk;
    ext_access dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_we(i_cfg_we), .i_cfg(i_cfg),
        .i_req(i_req), .i_req_info(i_req_info), .i_ext_rdata(i_ext_rdata), .o_cfg(o_cfg),
        .o_bus(o_bus), .o_internal(o_internal), .o_done(o_done), .o_rdata(o_rdata),
        .o_busy(o_busy));
    ext_periph_model periph (.i_clk(i_clk), .i_bus(o_bus), .o_rdata(i_ext_rdata),
        .o_sel(m_sel), .o_addr(m_addr), .o_we(m_we), .o_unstable(m_bad));
    function automatic logic [3:0] wt(input logic [2:0] n, input logic m);
        return m ? {n, 1'b1} : {1'b0, n};
    endfunction
    function automatic logic [2:0] cnt(input row_t r);
        logic [3:0][2:0] io = {3'h6, 3'h4, 3'h2, 3'h1};
        return r.sp == PM ? 3'h5 : r.sp == DM ? 3'h3 : io[r.addr[10:9]];
    endfunction
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic cfg_load(input logic m, input logic [1:0] ovl, input logic [2:0] pm);
        @(posedge i_clk);
        #1;
        // carrier has no reserved bits, so every written bit is defined
        i_cfg = '{pm, 3'h3, {3'h6, 3'h4, 3'h2, 3'h1}, m, ovl};
        i_cfg_we = 1'b1;
        @(posedge i_clk);
        #1;
        i_cfg_we = 1'b0;
    endtask
    // request held until the done cycle, dropped there
    task automatic run(input row_t r);
        @(posedge i_clk);
        #1;
        i_req_info = '{r.sp, r.wr, r.addr, r.wdata};
        i_req = 1'b1;
        for (lat = 1; lat <= 40; lat++) begin
            @(posedge i_clk);
            #1;
            if (lat == 1) busy1 = o_busy;
            if (poke) begin
                i_cfg_we = (lat == 2);
                i_cfg = '1;
            end
            if (o_done === 1'b1) break;
        end
        i_req = 1'b0;
        if (lat > 40) begin
            bad_count++;
            wrap_up();
        end
    endtask
    initial begin
        poke = 1'b0;
        rows = '{'{DM, 0, 14'h0100, 16'h0, 2'h0, 14'h0, 1, 16'h0},
            '{DM, 0, 14'h2ABC, 16'h0, 2'h0, 14'h0, 1, 16'h0},
            '{DM, 1, 14'h2ABC, 16'h1357, 2'h1, 14'h0ABC, 0, 16'h0},
            '{DM, 0, 14'h2ABC, 16'h0, 2'h1, 14'h0ABC, 0, 16'h1357},
            '{DM, 0, 14'h3FFF, 16'h0, 2'h2, 14'h3FFF, 0, 16'hC01F},
            '{PM, 1, 14'h1234, 16'h2468, 2'h0, 14'h1234, 0, 16'h0},
            '{PM, 0, 14'h1234, 16'h0, 2'h2, 14'h1234, 0, 16'h2468},
            '{IO, 0, 14'h3801, 16'h0, 2'h0, 14'h0001, 0, 16'hC021},
            '{IO, 1, 14'h3BFF, 16'hBEEF, 2'h0, 14'h03FF, 0, 16'h0},
            '{IO, 0, 14'h0400, 16'h0, 2'h0, 14'h0400, 0, 16'hC020},
            '{IO, 0, 14'h07FF, 16'h0, 2'h0, 14'h07FF, 0, 16'hBEEF}};
        repeat (4) @(posedge i_clk);
        #1;
        i_rst_b = 1'b1;
        chk(o_cfg, 32'h1FFFF8);
        chk({o_bus.pm_sel_b, o_bus.dm_sel_b, o_bus.io_sel_b, o_bus.rd_b, o_bus.wr_b,
            o_bus.data_oe}, 6'h3E);
        for (int m = 0; m < 2; m++) begin
            foreach (rows[i]) begin
                cfg_load(m[0], rows[i].ovl, 3'h5);
                run(rows[i]);
                // reads add two cycles for the read data synchroniser
                want = rows[i].intl ? 1 : wt(cnt(rows[i]), m[0]) + (rows[i].wr ? 2 : 4);
                chk(lat, want);
                chk(o_internal, rows[i].intl);
                chk(busy1, !rows[i].intl);
                if (!rows[i].intl) begin
                    chk(m_addr, rows[i].eaddr);
                    chk(m_sel, rows[i].sp == PM ? 3'h3 :
                        rows[i].sp == DM ? 3'h5 : 3'h6);
                    chk(m_we, rows[i].wr);
                    if (!rows[i].wr) chk(o_rdata, rows[i].rdata);
                end
            end
        end
        run(rows[5]);
        run(rows[6]);
        chk(o_rdata, 16'h2468);
        // config write during a long access must be ignored
        cfg_load(1'b1, 2'h0, 3'h7);
        poke = 1'b1;
        run(rows[6]);
        poke = 1'b0;
        chk(lat, 19);
        chk(o_cfg, {3'h7, 3'h3, 12'hD11, 1'b1, 2'h0});
        chk(m_bad, 1'b0);
        @(posedge i_clk);
        #1;
        i_req_info = '{PM, 1'b0, 14'h1234, 16'h0};
        i_req = 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        i_rst_b = 1'b0;
        i_req = 1'b0;
        #1;
        chk(o_cfg, 32'h1FFFF8);
        chk({o_busy, o_bus.rd_b, o_bus.pm_sel_b}, 3'h3);
        @(posedge i_clk);
        #1;
        i_rst_b = 1'b1;
        run(rows[6]);
        chk(lat, 11);
        // zero programmed waits: one strobe cycle, reads still pass the synchroniser
        cfg_load(1'b0, 2'h0, 3'h0);
        run(rows[5]);
        chk(lat, 2);
        run(rows[6]);
        chk(lat, 4);
        chk(o_rdata, 16'h2468);
        wrap_up();
    end
endmodule
